// File: bench/pmi_asserts.sv
// Checks on the two-wire bus between the two ends.
`timescale 1ns/100ps
module pmi_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Drives and wires
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Start and stop as seen on the wires.
  sequence start_s; scl && $past(scl) && $fell(sda); endsequence
  sequence stop_s; scl && $past(scl) && $rose(sda); endsequence
  ////////////////////////////////////////////////////////////////
  // Open-drain drivers only ever pull low.
  dev_od_low_a: assert property (sda_d_oe |-> !sda_d_o) else $error("device drives sda high");
  mst_scl_od_a: assert property (scl_m_oe |-> !scl_m_o) else $error("master drives scl high");
  mst_sda_od_a: assert property (sda_m_oe |-> !sda_m_o) else $error("master drives sda high");
  // The device only changes data while the clock is low.
  dev_drive_low_a: assert property ($rose(sda_d_oe) |-> !scl) else $error("device drive on high scl");
  dev_stable_hi_a: assert property (scl && $past(scl) |-> $stable(sda_d_oe)) else $error("drive moved");
  // The device keeps off the bus after reset, START and STOP.
  dev_deaf_rst_a: assert property ($rose(rstn) |-> !sda_d_oe [*8]) else $error("drive after reset");
  dev_quiet_st_a: assert property (start_s |-> !sda_d_oe [*6]) else $error("drive after start");
  dev_quiet_sp_a: assert property (stop_s |-> !sda_d_oe [*8]) else $error("drive after stop");
endmodule

// File: bench/power_monitor_i2c_slave_port_bench.sv
// Self-checking bench with both ends of the two-wire port.
`timescale 1ns/100ps
module power_monitor_i2c_slave_port_bench;
  import pmi_pkg::*;
  logic      clk, rstn, cmd_valid, cmd_ready, cmd_read, cmd_hs, cmd_group;
  logic      rsp_valid, rsp_nack, hs_active, wr_valid, wr_ready, hs_mode, busy, stall;
  logic [6:0] cmd_dev, own_addr, my_addr;
  logic [1:0] addr_strap_high, addr_strap_mid, addr_strap_low;
  pmi_byte_t cmd_word, rd_ptr, wr_addr;
  pmi_word_t cmd_wdata, rsp_rdata, wr_data, rd_word, d;
  logic [17:0] e;
  int        n_mismatch, n_checks, cyc;
  integer    seed;
  logic [17:0] eq[$];
  logic [23:0] wq[$];
  // Register file content seen by the device.
  function automatic pmi_word_t rdw(pmi_byte_t p);
    return {p ^ 8'hA5, p};
  endfunction
  assign rd_word = rdw(rd_ptr);
  pmi_if bus ();
  pmi_mst pmi_mst_inst (.*);
  pmi_dev pmi_dev_inst (.*);
  pmi_asserts pmi_asserts_inst (.clk(clk), .rstn(rstn), .scl_m_o(bus.scl_m_o), .scl_m_oe(bus.scl_m_oe),
    .sda_m_o(bus.sda_m_o), .sda_m_oe(bus.sda_m_oe), .sda_d_o(bus.sda_d_o), .sda_d_oe(bus.sda_d_oe),
    .scl(bus.scl), .sda(bus.sda));
  ////////////////////////////////////////////////////////////////
  // Clock.
  initial begin
    clk = 1'h0;
    forever #12.5 clk = !clk;
  end
  // Compare and count.
  task automatic chk(logic [23:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One command: note the expected answer, issue, wait for the answer.
  task automatic cmd(logic r, h, g, logic [6:0] a, pmi_byte_t w, logic n);
    eq.push_back({n, r, r ? rdw(w) : 16'h0000});
    chk(cmd_ready, 1'h1);
    @(posedge clk);
    {cmd_valid, cmd_read, cmd_hs, cmd_group} <= {1'h1, r, h, g};
    {cmd_dev, cmd_word, cmd_wdata} <= {a, w, d};
    @(posedge clk);
    cmd_valid <= 1'h0;
    @(negedge clk iff rsp_valid);
    for (int k = 0; k < 50 && busy; k++) @(negedge clk);
  endtask
  // Answers and committed writes against the notes.
  always @(negedge clk) begin
    if (rsp_valid === 1'h1) begin
      e = eq.size() ? eq.pop_front() : 18'h3FFFF;
      chk(rsp_nack, e[17]);
      if (e[16]) chk(rsp_rdata, e[15:0]);
    end
    if (hs_active === 1'h1) chk(hs_mode, 1'h1);
    if (wr_valid && wr_ready) chk({wr_addr, wr_data}, wq.size() ? wq.pop_front() : 24'hX);
  end
  // Random receiver stalls and the run limit.
  always @(posedge clk) begin
    wr_ready <= !stall && ($random(seed) % 2 != 0);
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seed = 32'h67A3;
    {cmd_valid, cmd_read, cmd_hs, cmd_group, stall, wr_ready, rstn} = '0;
    {cmd_dev, cmd_word, cmd_wdata, n_mismatch, n_checks, cyc} = '0;
    {addr_strap_high, addr_strap_mid, addr_strap_low} = 6'($random(seed)) & 6'h1F;
    my_addr = {ADDR_LEAD, addr_strap_high, addr_strap_mid, addr_strap_low};
    d = 16'($random(seed));
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    repeat (70) @(negedge clk);
    chk(own_addr, my_addr);
    chk(rd_ptr, PTR_RESET);
    $display("straps done");
    wq.push_back({8'h3C, d});
    cmd(1'h0, 1'h0, 1'h1, my_addr, 8'h3C, 1'h0);
    chk(wr_valid, 1'h0);
    cmd(1'h0, 1'h0, 1'h0, my_addr, 8'h3C, 1'h0);
    $display("group write done");
    cmd(1'h1, 1'h0, 1'h0, my_addr, 8'h3C, 1'h0);
    chk(rd_ptr, 8'h3D);
    cmd(1'h0, 1'h0, 1'h0, my_addr ^ 7'h01, 8'h10, 1'h1);
    $display("read and mismatch done");
    stall = 1'h1;
    for (int i = 0; i < 3; i++) begin
      if (i < 2) wq.push_back({8'(i), d});
      cmd(1'h0, 1'h1, 1'h0, my_addr, 8'(i), i == 2);
      chk(hs_mode, 1'h0);
    end
    stall = 1'h0;
    for (int k = 0; k < 200 && wr_valid; k++) @(negedge clk);
    chk(wq.size(), 0);
    $display("fast writes done");
    report_and_stop();
  end
endmodule

// File: pkg/pmi_if.sv
// Two-wire bus joining the master end and the device end.
`timescale 1ns/100ps
interface pmi_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // Open-drain wires with pull-ups: any enabled low driver wins.
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));
  modport device (input scl, sda, output sda_d_o, sda_d_oe);
  modport master (input scl, sda, output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe);
endinterface

// File: pkg/pmi_pkg.sv
// Shared constants and types for the power monitor two-wire port.
package pmi_pkg;
  // Clock and bus rates.
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned SCL_STD_HZ = 100_000;
  localparam int unsigned SCL_HS_HZ  = 3_400_000;
  // A bit has four quarters; the shortest quarter rounds up to whole cycles.
  localparam int unsigned Q_STD_CYC  = (CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
  localparam int unsigned Q_HS_CYC   = (CLK_HZ + 4 * SCL_HS_HZ - 1) / (4 * SCL_HS_HZ);
  localparam logic [6:0]  Q_STD_LOAD = 7'(Q_STD_CYC - 1);
  localparam logic [6:0]  Q_HS_LOAD  = 7'(Q_HS_CYC - 1);
  // Power-up window during which the port stays deaf.
  localparam logic [6:0]  PWRUP_CNT  = 7'h40;
  // Strap level codes and address layout.
  localparam logic [1:0]  LVL_GND    = 2'h0;
  localparam logic [1:0]  LVL_SUPPLY = 2'h1;
  localparam logic [1:0]  LVL_SDA    = 2'h2;
  localparam logic [1:0]  LVL_SCL    = 2'h3;
  localparam logic        ADDR_LEAD  = 1'h1;
  localparam logic        RW_READ    = 1'h1;
  localparam logic        RW_WRITE   = 1'h0;
  // Master code that opens high-speed mode.
  localparam logic [4:0]  MCODE_TOP  = 5'h01;
  localparam logic [7:0]  MCODE_BYTE = 8'h08;
  // Reset values and counts.
  localparam logic [7:0]  PTR_RESET  = 8'h00;
  localparam logic [3:0]  BIT_ACK    = 4'h8;
  localparam int unsigned BUF_W      = 24;
  // Master step indices.
  localparam logic [3:0]  STEP_HS    = 4'h0;
  localparam logic [3:0]  STEP_HS_SR = 4'h2;
  localparam logic [3:0]  STEP_FIRST = 4'h3;
  localparam logic [3:0]  STEP_WR_END = 4'h8;
  localparam logic [3:0]  STEP_RD_END = 4'hA;
  typedef logic [7:0]  pmi_byte_t;
  typedef logic [15:0] pmi_word_t;
endpackage

// File: verilog/pmi_buf2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module pmi_buf2 #(
  parameter int unsigned W = pmi_pkg::BUF_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_reg [2];
  logic         wp_reg;
  logic         rp_reg;
  logic [1:0]   cnt_reg;
  logic         push;
  logic         pop;

  // Handshakes and honest full and empty.
  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rp_reg];

  // Storage needs no reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        wp_reg <= !wp_reg;
      end
      if (pop) begin
        rp_reg <= !rp_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// File: verilog/pmi_dev.sv
// Device end of the power monitor two-wire slave port.
// Operation
// - Standard bus rate is 100 kHz.
// - Address comes from three four-level straps.
// - Address is one then two bits per strap.
// - Master avoids the reserved strap combinations.
// - Address bit zero: one reads, zero writes.
// - Acknowledge address byte only on a match.
// - Register pointer starts at zero.
// - Random read repeats the same address byte.
// - Write is address, pointer, high, low, STOP.
// - Acknowledge four write bytes, then stand by.
// - Read opens with pointer write, repeated START.
// - Send high byte, low only after acknowledge.
// - Master ends read with no acknowledge.
// - Pointer loads from address, steps per pair; only read pairs step it, writes leave it.
// - Chained writes take effect at final STOP; only the last word of the chain is kept.
// - Master never reads back in a group.
// - Master code opens high-speed mode.
// - STOP leaves high-speed mode, repeated START keeps.
// - START and STOP change data with clock high.
// - High byte first, most significant bit first.
// - Ignore START during power-up, data pin input.
`timescale 1ns/100ps
module pmi_dev (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Two-wire bus
  pmi_if.device                 bus,
  // Address straps, each a level code
  input  wire logic [1:0]       addr_strap_high,
  input  wire logic [1:0]       addr_strap_mid,
  input  wire logic [1:0]       addr_strap_low,
  // Register read side
  output pmi_pkg::pmi_byte_t    rd_ptr,
  input  wire pmi_pkg::pmi_word_t rd_word,
  // Register write side
  output logic                  wr_valid,
  input  wire logic             wr_ready,
  output pmi_pkg::pmi_byte_t    wr_addr,
  output pmi_pkg::pmi_word_t    wr_data,
  // Status
  output logic                  hs_mode,
  output logic [6:0]            own_addr,
  output logic                  busy
);
  import pmi_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h3,
    ST_WORD = 4'h2,
    ST_WACK = 4'h6,
    ST_RX   = 4'h7,
    ST_RACK = 4'h5,
    ST_TX   = 4'h4,
    ST_TACK = 4'hC,
    ST_HOLD = 4'hD
  } pmi_state_t;

  pmi_state_t state_reg;
  logic [2:0] scl_s_reg;
  logic [2:0] sda_s_reg;
  logic       scl_f_reg;
  logic       sda_f_reg;
  logic       scl_q_reg;
  logic       sda_q_reg;
  logic [6:0] pwr_cnt_reg;
  logic       ready_reg;
  logic [6:0] own_addr_reg;
  pmi_byte_t  sh_reg;
  pmi_byte_t  tx_lo_reg;
  pmi_byte_t  ptr_reg;
  pmi_byte_t  dhi_reg;
  pmi_byte_t  pend_addr_reg;
  pmi_word_t  pend_data_reg;
  logic       pend_valid_reg;
  logic [3:0] bit_reg;
  logic       rw_reg;
  logic       lo_reg;
  logic       mack_reg;
  logic       sda_oe_reg;
  logic       hs_reg;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  logic       run;
  logic       rx_state;
  logic       rx_done;
  logic       addr_ack;
  logic       buf_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass three flip-flops; a level counts once the last two agree.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_s_reg <= {scl_s_reg[1:0], bus.scl};
      sda_s_reg <= {sda_s_reg[1:0], bus.sda};
      if (scl_s_reg[2] == scl_s_reg[1]) begin
        scl_f_reg <= scl_s_reg[2];
      end
      if (sda_s_reg[2] == sda_s_reg[1]) begin
        sda_f_reg <= sda_s_reg[2];
      end
      scl_q_reg <= scl_f_reg;
      sda_q_reg <= sda_f_reg;
    end
  end

  // Bus events; data moving while the clock stays high marks START or STOP.
  assign scl_rise = scl_f_reg && !scl_q_reg;
  assign scl_fall = !scl_f_reg && scl_q_reg;
  assign start_ev = scl_f_reg && scl_q_reg && sda_q_reg && !sda_f_reg;
  assign stop_ev  = scl_f_reg && scl_q_reg && !sda_q_reg && sda_f_reg;
  assign run      = ready_reg && !start_ev && !stop_ev;
  assign rx_state = (state_reg == ST_ADDR) || (state_reg == ST_WORD) || (state_reg == ST_RX);
  assign rx_done  = run && rx_state && scl_fall && (bit_reg == BIT_ACK);
  // A write is taken only while the buffer can hold it at STOP.
  assign addr_ack = (sh_reg[7:1] == own_addr_reg) && (sh_reg[0] || buf_in_ready);

  ////////////////////////////////////////////////////////////////////////////
  // Power-up window; straps are caught by the clock while it runs.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwr_cnt_reg  <= 7'h00;
      ready_reg    <= 1'b0;
      own_addr_reg <= 7'h00;
    end else if (!ready_reg) begin
      pwr_cnt_reg  <= pwr_cnt_reg + 7'h01;
      ready_reg    <= (pwr_cnt_reg == PWRUP_CNT - 7'h01);
      own_addr_reg <= {ADDR_LEAD, addr_strap_high, addr_strap_mid, addr_strap_low};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine: shifting, acknowledge and data drive on the data line.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= ST_IDLE;
      sh_reg     <= 8'h00;
      tx_lo_reg  <= 8'h00;
      bit_reg    <= 4'h0;
      rw_reg     <= 1'b0;
      lo_reg     <= 1'b0;
      mack_reg   <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (!ready_reg) begin
      state_reg  <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_ev) begin
      state_reg  <= ST_ADDR;
      bit_reg    <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_ev) begin
      state_reg  <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      if (rx_state && scl_rise) begin
        sh_reg  <= {sh_reg[6:0], sda_f_reg};
        bit_reg <= bit_reg + 4'h1;
      end
      unique case (state_reg)
        ST_IDLE, ST_HOLD: begin
          sda_oe_reg <= 1'b0;
        end
        ST_ADDR: begin
          if (rx_done && addr_ack) begin
            state_reg  <= ST_AACK;
            sda_oe_reg <= 1'b1;
            rw_reg     <= sh_reg[0];
          end else if (rx_done) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_reg <= 4'h0;
            lo_reg  <= 1'b0;
            if (rw_reg) begin
              state_reg  <= ST_TX;
              sh_reg     <= rd_word[15:8];
              tx_lo_reg  <= rd_word[7:0];
              sda_oe_reg <= !rd_word[15];
            end else begin
              state_reg  <= ST_WORD;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        ST_WORD: begin
          if (rx_done) begin
            state_reg  <= ST_WACK;
            sda_oe_reg <= 1'b1;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            state_reg  <= ST_RX;
            bit_reg    <= 4'h0;
            sda_oe_reg <= 1'b0;
          end
        end
        ST_RX: begin
          if (rx_done) begin
            state_reg  <= ST_RACK;
            sda_oe_reg <= 1'b1;
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            bit_reg    <= 4'h0;
            lo_reg     <= 1'b1;
            state_reg  <= lo_reg ? ST_HOLD : ST_RX;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_reg <= bit_reg + 4'h1;
          end
          if (scl_fall && (bit_reg == BIT_ACK)) begin
            state_reg  <= ST_TACK;
            sda_oe_reg <= 1'b0;
          end else if (scl_fall) begin
            sh_reg     <= {sh_reg[6:0], 1'b0};
            sda_oe_reg <= !sh_reg[6];
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            mack_reg <= !sda_f_reg;
          end
          if (scl_fall && mack_reg && !lo_reg) begin
            state_reg  <= ST_TX;
            sh_reg     <= tx_lo_reg;
            lo_reg     <= 1'b1;
            bit_reg    <= 4'h0;
            sda_oe_reg <= !tx_lo_reg[7];
          end else if (scl_fall) begin
            state_reg <= ST_HOLD;
          end
        end
        default: begin
          state_reg  <= ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register pointer: loaded by the word address, stepped after each pair read out.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_reg <= PTR_RESET;
    end else if (rx_done && (state_reg == ST_WORD)) begin
      ptr_reg <= sh_reg;
    end else if (run && scl_fall && (state_reg == ST_TACK) && lo_reg) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // A received word waits for STOP; a later word in a chain replaces it, so only the last is committed.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dhi_reg        <= 8'h00;
      pend_addr_reg  <= 8'h00;
      pend_data_reg  <= 16'h0000;
      pend_valid_reg <= 1'b0;
    end else if (stop_ev) begin
      pend_valid_reg <= 1'b0;
    end else if (rx_done && (state_reg == ST_RX) && !lo_reg) begin
      dhi_reg <= sh_reg;
    end else if (rx_done && (state_reg == ST_RX)) begin
      pend_addr_reg  <= ptr_reg;
      pend_data_reg  <= {dhi_reg, sh_reg};
      pend_valid_reg <= 1'b1;
    end
  end

  // High-speed flag: set by the master code, kept over repeated START.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hs_reg <= 1'b0;
    end else if (stop_ev) begin
      hs_reg <= 1'b0;
    end else if (rx_done && (state_reg == ST_ADDR) && (sh_reg[7:3] == MCODE_TOP)) begin
      hs_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Committed writes pass the buffer, so a slow consumer loses no word.
  pmi_buf2 #(
    .W (BUF_W)
  ) u_wbuf (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (stop_ev && pend_valid_reg),
    .in_ready  (buf_in_ready),
    .in_data   ({pend_addr_reg, pend_data_reg}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );

  // Open-drain data drive and status.
  assign bus.sda_d_o  = 1'b0;
  assign bus.sda_d_oe = sda_oe_reg;
  assign rd_ptr       = ptr_reg;
  assign hs_mode      = hs_reg;
  assign own_addr     = own_addr_reg;
  assign busy         = (state_reg != ST_IDLE);
endmodule

// File: verilog/pmi_mst.sv
// Master end of the power monitor two-wire port.
`timescale 1ns/100ps
module pmi_mst (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Two-wire bus
  pmi_if.master                   bus,
  // Command port
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire logic               cmd_read,
  input  wire logic               cmd_hs,
  input  wire logic               cmd_group,
  input  wire logic [6:0]         cmd_dev,
  input  wire pmi_pkg::pmi_byte_t cmd_word,
  input  wire pmi_pkg::pmi_word_t cmd_wdata,
  // Response port
  output logic                    rsp_valid,
  output logic                    rsp_nack,
  output pmi_pkg::pmi_word_t      rsp_rdata,
  output logic                    hs_active
);
  import pmi_pkg::*;

  typedef enum logic [2:0] {OP_START, OP_TX, OP_RX, OP_STOP, OP_END} pmi_op_t;

  logic [2:0] sda_s_reg;
  logic       sda_f_reg;
  logic       busy_reg;
  logic       rd_reg;
  logic       grp_reg;
  logic       err_reg;
  logic       hs_reg;
  logic       rsp_reg;
  logic       scl_low_reg;
  logic       sda_low_reg;
  logic [6:0] dev_reg;
  logic [6:0] q_cnt_reg;
  pmi_byte_t  word_reg;
  pmi_word_t  wdat_reg;
  pmi_word_t  rdat_reg;
  logic [3:0] step_reg;
  logic [3:0] bit_reg;
  logic [1:0] ph_reg;
  pmi_op_t    op;
  pmi_byte_t  tx_byte;
  logic       sda_ph0;
  logic       tick;
  logic       done;
  logic       finish;
  logic       nack_now;

  ////////////////////////////////////////////////////////////////////////////
  // Step table of one transaction.
  always_comb begin
    unique case (step_reg)
      4'h0, 4'h2, 4'h3: op = OP_START;
      4'h6:             op = rd_reg ? OP_START : OP_TX;
      4'h8:             op = rd_reg ? OP_RX : ((grp_reg && !err_reg) ? OP_END : OP_STOP);
      4'h9:             op = OP_RX;
      4'hA:             op = OP_STOP;
      default:          op = OP_TX;
    endcase
    unique case (step_reg)
      4'h1:    tx_byte = MCODE_BYTE;
      4'h5:    tx_byte = word_reg;
      4'h6:    tx_byte = wdat_reg[15:8];
      4'h7:    tx_byte = rd_reg ? {dev_reg, RW_READ} : wdat_reg[7:0];
      default: tx_byte = {dev_reg, RW_WRITE};
    endcase
    unique case (op)
      OP_START: sda_ph0 = 1'b0;
      OP_TX:    sda_ph0 = (bit_reg != BIT_ACK) && !tx_byte[3'(4'h7 - bit_reg)];
      OP_RX:    sda_ph0 = (bit_reg == BIT_ACK) && (step_reg == STEP_WR_END);
      default:  sda_ph0 = 1'b1;
    endcase
  end

  // Quarter-bit tick, one cycle pulse from a divider.
  assign tick     = busy_reg && (q_cnt_reg == 7'h00);
  assign done     = tick && ((op == OP_END) || ((ph_reg == 2'h3) &&
                    ((op == OP_START) || (op == OP_STOP) || (bit_reg == BIT_ACK))));
  assign finish   = done && ((op == OP_END) || (op == OP_STOP));
  // The acknowledge is read on the last quarter, so a slow turnaround at the high rate still lands in time.
  assign nack_now = (op == OP_TX) && sda_f_reg && (step_reg != 4'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Data line sampled by three flip-flops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_s_reg <= 3'h7;
      sda_f_reg <= 1'b1;
    end else begin
      sda_s_reg <= {sda_s_reg[1:0], bus.sda};
      if (sda_s_reg[2] == sda_s_reg[1]) begin
        sda_f_reg <= sda_s_reg[2];
      end
    end
  end

  // Rate divider: standard rate until the repeated START after the master code.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_cnt_reg <= Q_STD_LOAD;
    end else if (!busy_reg || tick) begin
      q_cnt_reg <= hs_reg ? Q_HS_LOAD : Q_STD_LOAD;
    end else begin
      q_cnt_reg <= q_cnt_reg - 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: command capture, step, bit and quarter counting.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
      rd_reg   <= 1'b0;
      grp_reg  <= 1'b0;
      err_reg  <= 1'b0;
      dev_reg  <= 7'h00;
      word_reg <= 8'h00;
      wdat_reg <= 16'h0000;
      step_reg <= STEP_FIRST;
      bit_reg  <= 4'h0;
      ph_reg   <= 2'h0;
      rsp_reg  <= 1'b0;
    end else begin
      rsp_reg <= finish;
      if (!busy_reg && cmd_valid) begin
        busy_reg <= 1'b1;
        rd_reg   <= cmd_read;
        grp_reg  <= cmd_group;
        dev_reg  <= cmd_dev;
        word_reg <= cmd_word;
        wdat_reg <= cmd_wdata;
        err_reg  <= 1'b0;
        step_reg <= cmd_hs ? STEP_HS : STEP_FIRST;
        bit_reg  <= 4'h0;
        ph_reg   <= 2'h0;
      end else if (tick) begin
        ph_reg <= done ? 2'h0 : ph_reg + 2'h1;
        if ((ph_reg == 2'h3) && ((op == OP_TX) || (op == OP_RX))) begin
          bit_reg <= (bit_reg == BIT_ACK) ? 4'h0 : bit_reg + 4'h1;
        end
        if (finish) begin
          busy_reg <= 1'b0;
        end else if (done && nack_now) begin
          err_reg  <= 1'b1;
          step_reg <= rd_reg ? STEP_RD_END : STEP_WR_END;
        end else if (done) begin
          step_reg <= (step_reg == STEP_HS_SR) ? STEP_FIRST + 4'h1 : step_reg + 4'h1;
        end
      end
    end
  end

  // Pin drive; data moves with the clock low except for START and STOP.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else if (tick && (op != OP_END)) begin
      if (ph_reg == 2'h0) begin
        sda_low_reg <= sda_ph0;
      end
      if (ph_reg == 2'h1) begin
        scl_low_reg <= 1'b0;
      end
      if ((ph_reg == 2'h2) && ((op == OP_START) || (op == OP_STOP))) begin
        sda_low_reg <= (op == OP_START);
      end
      if ((ph_reg == 2'h3) && (op != OP_STOP)) begin
        scl_low_reg <= 1'b1;
      end
    end
  end

  // Read data is sampled just before the clock falls, and the high-speed flag follows the master code.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdat_reg <= 16'h0000;
      hs_reg   <= 1'b0;
    end else begin
      if (tick && (ph_reg == 2'h3) && (op == OP_RX) && (bit_reg != BIT_ACK)) begin
        rdat_reg <= {rdat_reg[14:0], sda_f_reg};
      end
      if (done && (op == OP_STOP)) begin
        hs_reg <= 1'b0;
      end else if (done && (step_reg == STEP_HS_SR)) begin
        hs_reg <= 1'b1;
      end
    end
  end

  // Outputs.
  assign bus.scl_m_o  = 1'b0;
  assign bus.scl_m_oe = scl_low_reg;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = sda_low_reg;
  assign cmd_ready    = !busy_reg;
  assign rsp_valid    = rsp_reg;
  assign rsp_nack     = err_reg;
  assign rsp_rdata    = rdat_reg;
  assign hs_active    = hs_reg;
endmodule
